// ==== rtl/spm_pkg.sv ====
// package for the shared pin function multiplexer
// assumes one system clock and an active-low power-on reset
// Function
// - reset samples upper address pins into config straps
// - reset samples boot pins and direction pin
// - after reset strap pins become memory outputs
// - mode registers select function of pins 31..0
// - config straps select function of pins 44..32
// - host bus pins shareable with diagnosis, trace, gpio
// - diagnosis signals only on shared pins, driven out
// - uart signals on pins 8 to 12
// - spi1 signals on pins 16 to 23
// - sync clock pins 24, 25 via high mode
// - pin 25 drives ALT1_DRV.o[25], not SYNC_CLOCK_OUT_N, when selected
// - four choices per pin 31..0, zero after reset
package spm_pkg;
   // ***************************************************
   // widths and field positions
   // ***************************************************
   localparam int GPIO_LO_N    = 32;
   localparam int GPIO_HI_N    = 13;
   localparam int MODE_W       = 2;
   localparam int CFG_W        = 6;
   localparam int BOOT_W       = 4;
   localparam int ADDR_W       = 24;
   localparam int CFG_LSB      = 18;
   localparam int BOOT_LSB     = 15;
   localparam int HBUS_W       = 16;
   localparam int TRACE_W      = 14;
   // config strap bit that hands pins 44..32 to gpio instead of host bus
   localparam int CFG_HI_GPIO  = 0;
   // config strap bits choosing host-bus low pins: 00 bus, 01 diag, 10 trace
   localparam int CFG_SEL_LSB  = 1;
   localparam logic [1:0] LOW_BUS   = 2'h0;
   localparam logic [1:0] LOW_DIAG  = 2'h1;
   localparam logic [1:0] LOW_TRACE = 2'h2;
   // ***************************************************
   // pin positions
   // ***************************************************
   localparam int PIN_UART_LO  = 8;
   localparam int PIN_UART_HI  = 12;
   localparam int PIN_SPI_LO   = 16;
   localparam int PIN_SPI_HI   = 23;
   localparam int PIN_SYNC_IN  = 24;
   localparam int PIN_SYNC_OUT = 25;
   localparam int PIN_DBG_REQ  = 31;
   // ***************************************************
   // types
   // ***************************************************
   typedef enum logic [1:0] {
      SPM_FN_GPIO = 2'b00,
      SPM_FN_ALT1 = 2'b01,
      SPM_FN_ALT2 = 2'b10,
      SPM_FN_ALT3 = 2'b11
   } spm_fn_e;
   typedef struct packed {
      logic [GPIO_LO_N-1:0] o;
      logic [GPIO_LO_N-1:0] oe_n;
   } spm_drv_s;
   localparam logic [CFG_W-1:0]  CFG_RST  = 6'h00;
   localparam logic [BOOT_W-1:0] BOOT_RST = 4'h0;
endpackage

// ==== rtl/spm_pin_mux.sv ====
// shared pin function multiplexer: strap capture and pin routing
// assumes pins already synchronous to CLK; pads resolved outside
`timescale 1ns/1ps
module spm_pin_mux
   import spm_pkg::*;
(
   input  wire logic                    CLK,           // system clock
   input  wire logic                    NRST,          // power-on reset, low
   input  wire logic [ADDR_W-1:0]       MEM_ADDR,      // memory address from controller
   input  wire logic                    MEM_DIR,       // driver direction from controller
   input  wire logic [ADDR_W-1:0]       ADDR_PIN_I,    // address pad inputs
   output logic      [ADDR_W-1:0]       ADDR_PIN_O,    // address pad outputs
   output logic      [ADDR_W-1:0]       ADDR_PIN_OE_N, // address pad enables, low drives
   input  wire logic                    DIR_PIN_I,     // direction pad input
   output logic                         DIR_PIN_O,     // direction pad output
   output logic                         DIR_PIN_OE_N,  // direction pad enable
   output logic      [CFG_W-1:0]        CONFIG_STRAP,  // captured config straps
   output logic      [BOOT_W-1:0]       BOOT_STRAP,    // captured boot source
   input  wire logic [MODE_W*16-1:0]    PORT_MODE_L,   // mode for pins 15..0
   input  wire logic [MODE_W*16-1:0]    PORT_MODE_H,   // mode for pins 31..16
   input  wire spm_drv_s                GPIO_DRV,      // gpio block drive, pins 31..0
   output spm_drv_s                     GPIO_PAD,      // pad drive, pins 31..0
   input  wire logic [GPIO_LO_N-1:0]    GPIO_PIN_I,    // pad inputs, pins 31..0
   output logic      [GPIO_LO_N-1:0]    GPIO_IN,       // inputs to gpio block
   input  wire spm_drv_s                ALT1_DRV,      // function 1 drives (uart,spi,sync,led)
   input  wire spm_drv_s                ALT2_DRV,      // function 2 drives
   input  wire spm_drv_s                ALT3_DRV,      // function 3 drives
   output logic      [GPIO_LO_N-1:0]    ALT1_IN,       // function 1 inputs, gated
   output logic      [GPIO_LO_N-1:0]    ALT2_IN,       // function 2 inputs, gated
   input  wire logic                    SYNC_CLOCK_OUT_N,  // timing generator clock
   output logic                         SYNC_CLOCK_IN_N,   // sync clock input to pll
   output logic                         DEBUG_REQ,     // debug request to cpu
   input  wire logic [GPIO_HI_N-1:0]    HGPIO_O,       // gpio 44..32 outputs
   input  wire logic [GPIO_HI_N-1:0]    HGPIO_OE_N,    // gpio 44..32 enables
   output logic      [GPIO_HI_N-1:0]    HGPIO_IN,      // gpio 44..32 inputs
   input  wire logic [GPIO_HI_N-1:0]    HBUS_HI_O,     // host bus outputs on shared high pins
   input  wire logic [GPIO_HI_N-1:0]    HBUS_HI_OE_N,  // host bus enables on high pins
   output logic      [GPIO_HI_N-1:0]    HBUS_HI_IN,    // host bus inputs incl host_bus_addr_high
   input  wire logic [GPIO_HI_N-1:0]    HI_PIN_I,      // pad inputs, pins 44..32
   output logic      [GPIO_HI_N-1:0]    HI_PIN_O,      // pad outputs, pins 44..32
   output logic      [GPIO_HI_N-1:0]    HI_PIN_OE_N,   // pad enables, pins 44..32
   input  wire logic [HBUS_W-1:0]       HBUS_LO_O,     // host bus drive, low pins
   input  wire logic [HBUS_W-1:0]       HBUS_LO_OE_N,  // host bus enables, low pins
   output logic      [HBUS_W-1:0]       HBUS_LO_IN,    // host bus inputs, low pins
   input  wire logic [HBUS_W-1:0]       DIAG_O,        // diagnosis outputs
   input  wire logic [TRACE_W-1:0]      TRACE_O,       // trace outputs
   input  wire logic [HBUS_W-1:0]       LO_PIN_I,      // pad inputs, low shared pins
   output logic      [HBUS_W-1:0]       LO_PIN_O,      // pad outputs, low shared pins
   output logic      [HBUS_W-1:0]       LO_PIN_OE_N    // pad enables, low shared pins
);
   // ***************************************************
   // strap capture
   // ***************************************************
   logic [CFG_W-1:0]  cfg_reg;
   logic [BOOT_W-1:0] boot_reg;
   logic              run_reg;
   // straps follow the pins while reset holds; frozen at first clocked edge
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         run_reg <= 1'b0;
      end else begin
         run_reg <= 1'b1;
      end
   end
   // run_reg low means reset phase: pins still inputs, sample them
   always_ff @(posedge CLK) begin
      if (!run_reg) begin
         cfg_reg  <= ADDR_PIN_I[CFG_LSB +: CFG_W];
         boot_reg <= {ADDR_PIN_I[BOOT_LSB +: 3], DIR_PIN_I};
      end
   end
   assign CONFIG_STRAP = run_reg ? cfg_reg : CFG_RST;
   assign BOOT_STRAP   = run_reg ? boot_reg : BOOT_RST;
   // upper address and direction pins are inputs until run
   wire [ADDR_W-1:0] strap_mask = {{CFG_W+3{1'b1}}, {BOOT_LSB{1'b0}}};
   assign ADDR_PIN_O    = MEM_ADDR;
   assign ADDR_PIN_OE_N = run_reg ? '0 : strap_mask;
   assign DIR_PIN_O     = MEM_DIR;
   assign DIR_PIN_OE_N  = ~run_reg;
   // ***************************************************
   // low gpio mux, pins 31..0
   // ***************************************************
   wire [MODE_W*32-1:0] mode_all = {PORT_MODE_H, PORT_MODE_L};
   function automatic spm_fn_e fn_of(input logic [MODE_W*32-1:0] m, input int i);
      fn_of = spm_fn_e'(m[i*MODE_W +: MODE_W]);
   endfunction
   genvar g;
   generate
      for (g = 0; g < GPIO_LO_N; g++) begin : g_lo
         // mode inputs are reset to zero by their owner: gpio after reset
         wire spm_fn_e fn = fn_of(mode_all, g);
         wire sel1 = (fn == SPM_FN_ALT1);
         wire sel2 = (fn == SPM_FN_ALT2);
         wire sel3 = (fn == SPM_FN_ALT3);
         assign GPIO_PAD.o[g] = sel1 ? ALT1_DRV.o[g] : sel2 ? ALT2_DRV.o[g] :
                                sel3 ? ALT3_DRV.o[g] : GPIO_DRV.o[g];
         assign GPIO_PAD.oe_n[g] = sel1 ? ALT1_DRV.oe_n[g] : sel2 ? ALT2_DRV.oe_n[g] :
                                   sel3 ? ALT3_DRV.oe_n[g] : GPIO_DRV.oe_n[g];
         assign GPIO_IN[g] = (fn == SPM_FN_GPIO) & GPIO_PIN_I[g];
         assign ALT1_IN[g] = sel1 & GPIO_PIN_I[g];
         assign ALT2_IN[g] = sel2 & GPIO_PIN_I[g];
      end
   endgenerate
   // sync clock pins: only high mode word reaches pins 24,25
   wire fn24_alt = (fn_of(mode_all, PIN_SYNC_IN) == SPM_FN_ALT1);
   wire fn25_alt = (fn_of(mode_all, PIN_SYNC_OUT) == SPM_FN_ALT1);
   // inactive level high keeps active-low consumers idle
   assign SYNC_CLOCK_IN_N = fn24_alt ? GPIO_PIN_I[PIN_SYNC_IN] : 1'b1;
   assign DEBUG_REQ = (fn_of(mode_all, PIN_DBG_REQ) == SPM_FN_ALT1) &
                      GPIO_PIN_I[PIN_DBG_REQ];
   // ***************************************************
   // high gpio mux, pins 44..32, steered by strap
   // ***************************************************
   wire hi_gpio = cfg_reg[CFG_HI_GPIO] & run_reg;
   assign HI_PIN_O    = hi_gpio ? HGPIO_O : HBUS_HI_O;
   assign HI_PIN_OE_N = !run_reg ? '1 : hi_gpio ? HGPIO_OE_N : HBUS_HI_OE_N;
   assign HGPIO_IN    = hi_gpio ? HI_PIN_I : '0;
   assign HBUS_HI_IN  = hi_gpio ? '0 : HI_PIN_I;
   // ***************************************************
   // low shared host-bus pins: bus, diagnosis or trace
   // ***************************************************
   wire [1:0] low_sel = run_reg ? cfg_reg[CFG_SEL_LSB +: 2] : LOW_BUS;
   wire is_bus   = (low_sel == LOW_BUS) | (low_sel == 2'h3);
   wire is_diag  = (low_sel == LOW_DIAG);
   wire is_trace = (low_sel == LOW_TRACE);
   // diagnosis and trace are outputs only; no pin ever reads them back
   assign LO_PIN_O    = is_diag ? DIAG_O :
                        is_trace ? {{HBUS_W-TRACE_W{1'b0}}, TRACE_O} : HBUS_LO_O;
   assign LO_PIN_OE_N = !run_reg ? '1 : is_bus ? HBUS_LO_OE_N :
                        is_diag ? '0 : {{HBUS_W-TRACE_W{1'b1}}, {TRACE_W{1'b0}}};
   assign HBUS_LO_IN  = is_bus ? LO_PIN_I : '1;
   // ***************************************************
   // assertions
   // ***************************************************
   sequence s_rst_rel;
      !run_reg ##1 run_reg;
   endsequence
   AST_STRAP_HOLD: assert property (@(posedge CLK) disable iff (!NRST)
      run_reg && $past(run_reg) |-> $stable(CONFIG_STRAP) && $stable(BOOT_STRAP))
      else $error("straps changed after reset");
   AST_BOOT_DIR: assert property (@(posedge CLK) disable iff (!NRST)
      s_rst_rel |-> BOOT_STRAP[0] == $past(DIR_PIN_I, 1))
      else $error("boot bit 0 not from direction pin");
   AST_CFG_CAP: assert property (@(posedge CLK) disable iff (!NRST)
      s_rst_rel |-> CONFIG_STRAP == $past(ADDR_PIN_I[23:18], 1))
      else $error("config strap mismatch");
   AST_OUT_RUN: assert property (@(posedge CLK) disable iff (!NRST)
      run_reg |-> ADDR_PIN_OE_N == '0 && !DIR_PIN_OE_N)
      else $error("memory pins not driven after reset");
   AST_GPIO_DEF: assert property (@(posedge CLK) disable iff (!NRST)
      mode_all[MODE_W*9 +: MODE_W] == 2'h0 |-> ALT1_IN[9] == 1'b0 &&
      GPIO_IN[9] == GPIO_PIN_I[9])
      else $error("gpio 9 input misrouted");
   AST_SYNC_OUT: assert property (@(posedge CLK) disable iff (!NRST)
      fn25_alt |-> GPIO_PAD.o[25] == ALT1_DRV.o[25])
      else $error("sync clock not on pin 25");
   AST_HI_SEL: assert property (@(posedge CLK) disable iff (!NRST)
      run_reg && !CONFIG_STRAP[0] |-> HI_PIN_OE_N == HBUS_HI_OE_N)
      else $error("high pins not on host bus");
   AST_DIAG_OUT: assert property (@(posedge CLK) disable iff (!NRST)
      run_reg && CONFIG_STRAP[2:1] == 2'h1 |-> LO_PIN_OE_N == '0 &&
      HBUS_LO_IN == '1)
      else $error("diagnosis not driven out");
   AST_STRAP_ZERO: assert property (@(posedge CLK) disable iff (!NRST)
      !run_reg |-> CONFIG_STRAP == CFG_RST && BOOT_STRAP == BOOT_RST)
      else $error("straps visible before run");
   AST_STRAP_IN: assert property (@(posedge CLK) disable iff (!NRST)
      !run_reg |-> ADDR_PIN_OE_N[23:15] == 9'h1FF && DIR_PIN_OE_N)
      else $error("strap pins driven during reset");
   AST_SYNC_IDLE: assert property (@(posedge CLK) disable iff (!NRST)
      !fn24_alt |-> SYNC_CLOCK_IN_N)
      else $error("sync clock input not idle");
   AST_UART_RX: assert property (@(posedge CLK) disable iff (!NRST)
      fn_of(mode_all, 9) == SPM_FN_ALT1 |-> ALT1_IN[9] == GPIO_PIN_I[9])
      else $error("uart receive not routed");
   AST_SPI_RX: assert property (@(posedge CLK) disable iff (!NRST)
      fn_of(mode_all, 18) == SPM_FN_ALT1 |-> ALT1_IN[18] == GPIO_PIN_I[18])
      else $error("spi receive not routed");
   AST_HI_GPIO: assert property (@(posedge CLK) disable iff (!NRST)
      hi_gpio |-> HI_PIN_OE_N == HGPIO_OE_N && HBUS_HI_IN == '0)
      else $error("high pins not on gpio");
   AST_TRACE_OUT: assert property (@(posedge CLK) disable iff (!NRST)
      run_reg && low_sel == LOW_TRACE |-> LO_PIN_OE_N[TRACE_W-1:0] == '0)
      else $error("trace not driven out");
   AST_DBG_OFF: assert property (@(posedge CLK) disable iff (!NRST)
      fn_of(mode_all, PIN_DBG_REQ) != SPM_FN_ALT1 |-> !DEBUG_REQ)
      else $error("debug request leaks from gpio");
   // timing generator output is unused here; pin 25 takes ALT1_DRV.o[25] when alt1 is selected
   wire unused_sync = SYNC_CLOCK_OUT_N;
endmodule

// ==== dv/spm_pad_model.sv ====
// pad bank model for the far side of the shared pins
// assumes device enables are active low; the far side drives released pins while ext_en is high
`timescale 1ns/1ps
module spm_pad_model #(
   parameter int          W    = 8      // pins in the bank
) (
   input  wire logic [W-1:0] pull,   // pad pull levels
   input  wire logic [W-1:0] o,      // device drive
   input  wire logic [W-1:0] oe_n,   // device enable, low drives
   input  wire logic [W-1:0] ext,    // far side level
   input  wire logic         ext_en, // far side drives released pins
   output logic      [W-1:0] pin     // resolved pin level
);
   // released pins take the far side level when ext_en, else the pull, never a stale level
   always_comb begin
      for (int i = 0; i < W; i++) begin
         pin[i] = !oe_n[i] ? o[i] : (ext_en ? ext[i] : pull[i]);
      end
   end
endmodule

// ==== dv/shared_pin_function_mux_test.sv ====
// bench for the shared pin multiplexer: straps, strap routing, mode routing
// assumes pad banks are resolved by the pad model
`timescale 1ns/1ps
module shared_pin_function_mux_test import spm_pkg::*;;
   logic             CLK, NRST, MEM_DIR, DIR_PIN_I, DIR_PIN_O, DIR_PIN_OE_N, ext_en, dir_ext;
   logic             SYNC_CLOCK_OUT_N, SYNC_CLOCK_IN_N, DEBUG_REQ;
   logic [23:0]      MEM_ADDR, ADDR_PIN_I, ADDR_PIN_O, ADDR_PIN_OE_N, addr_ext;
   logic [5:0]       CONFIG_STRAP;
   logic [3:0]       BOOT_STRAP;
   logic [31:0]      PORT_MODE_L, PORT_MODE_H, GPIO_PIN_I, GPIO_IN, ALT1_IN, ALT2_IN;
   spm_drv_s         GPIO_DRV, GPIO_PAD, ALT1_DRV, ALT2_DRV, ALT3_DRV, e;
   logic [12:0]      HGPIO_O, HGPIO_OE_N, HGPIO_IN, HBUS_HI_O, HBUS_HI_OE_N, HBUS_HI_IN;
   logic [12:0]      HI_PIN_I, HI_PIN_O, HI_PIN_OE_N;
   logic [15:0]      HBUS_LO_O, HBUS_LO_OE_N, HBUS_LO_IN, DIAG_O, LO_PIN_I, LO_PIN_O, LO_PIN_OE_N;
   logic [13:0]      TRACE_O;
   logic [31:0]      g_ext, g_pull;
   logic [23:0]      a_pull;
   logic [15:0]      l_ext, l_pull;
   logic [12:0]      h_ext, h_pull;
   logic             d_pull, far_en;
   int               miscompares, total_checks, cycles;
   spm_pin_mux dut (.*);
   // address pulls: 23,21,19..17 up; 22,20,16,15 down
   spm_pad_model #(.W(24)) apad (.pull(a_pull), .o(ADDR_PIN_O), .oe_n(ADDR_PIN_OE_N),
      .ext(addr_ext), .ext_en(ext_en), .pin(ADDR_PIN_I));
   spm_pad_model #(.W(1)) dpad (.pull(d_pull), .o(DIR_PIN_O), .oe_n(DIR_PIN_OE_N),
      .ext(dir_ext), .ext_en(ext_en), .pin(DIR_PIN_I));
   spm_pad_model #(.W(32)) gpad (.pull(g_pull), .o(GPIO_PAD.o), .oe_n(GPIO_PAD.oe_n),
      .ext(g_ext), .ext_en(far_en), .pin(GPIO_PIN_I));
   spm_pad_model #(.W(13)) hpad (.pull(h_pull), .o(HI_PIN_O), .oe_n(HI_PIN_OE_N),
      .ext(h_ext), .ext_en(far_en), .pin(HI_PIN_I));
   spm_pad_model #(.W(16)) lpad (.pull(l_pull), .o(LO_PIN_O), .oe_n(LO_PIN_OE_N),
      .ext(l_ext), .ext_en(far_en), .pin(LO_PIN_I));
   always #2.5 CLK = ~CLK;
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      total_checks++;
      if (got !== ex) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // reset with strap levels on the pads, then normal memory drive
   task automatic t_straps(input logic [5:0] cfg, input logic [3:0] boot);
      @(negedge CLK);
      NRST = 1'b0; ext_en = 1'b1; dir_ext = boot[0]; addr_ext = {cfg, boot[3:1], 15'h0};
      repeat (8) @(negedge CLK);
      chk("cfg in reset", 32'h0, CONFIG_STRAP);
      chk("strap pads released", 32'h3FF, {ADDR_PIN_OE_N[23:15], DIR_PIN_OE_N});
      NRST = 1'b1;
      @(negedge CLK);
      ext_en = 1'b0;
      MEM_ADDR = ~addr_ext;
      MEM_DIR = ~boot[0];
      repeat (2) @(negedge CLK);
      chk("cfg strap", cfg, CONFIG_STRAP);
      chk("boot strap", boot, BOOT_STRAP);
      chk("addr out", MEM_ADDR, ADDR_PIN_O);
      chk("addr en", 32'h0, {ADDR_PIN_OE_N, DIR_PIN_OE_N});
      chk("dir out", MEM_DIR, DIR_PIN_O);
      $display("straps %h done", cfg);
   endtask
   // strap-selected routing of the host bus pins
   task automatic t_hilo(input logic [5:0] cfg);
      logic [15:0] eo, eoe, ein, msk;
      msk = 16'hFFFF;
      ein = 16'hFFFF;
      case (cfg[2:1])
         LOW_DIAG: begin eo = DIAG_O; eoe = 16'h0; end
         LOW_TRACE: begin eo = {2'b00, TRACE_O}; eoe = 16'hC000; msk = 16'h3FFF; end
         default: begin eo = HBUS_LO_O; eoe = HBUS_LO_OE_N; ein = LO_PIN_I; end
      endcase
      chk("lo out", eo & msk, LO_PIN_O & msk);
      chk("lo en", eoe, LO_PIN_OE_N);
      chk("lo in", ein, HBUS_LO_IN);
      chk("hi out", cfg[0] ? HGPIO_O : HBUS_HI_O, HI_PIN_O);
      chk("hi en", cfg[0] ? HGPIO_OE_N : HBUS_HI_OE_N, HI_PIN_OE_N);
      chk("hgpio in", cfg[0] ? HI_PIN_I : 13'h0, HGPIO_IN);
      chk("hbus in", cfg[0] ? 13'h0 : HI_PIN_I, HBUS_HI_IN);
      $display("host bus routing %h done", cfg);
   endtask
   // every mode on every low pin, then the sync clock output
   task automatic t_modes;
      for (int m = 0; m < 4; m++) begin
         @(negedge CLK);
         PORT_MODE_L = {16{m[1:0]}};
         PORT_MODE_H = {16{m[1:0]}};
         #1;
         e = (m == 0) ? GPIO_DRV : (m == 1) ? ALT1_DRV : (m == 2) ? ALT2_DRV : ALT3_DRV;
         chk("pad out", e.o, GPIO_PAD.o);
         chk("pad en", e.oe_n, GPIO_PAD.oe_n);
         chk("gpio in", (m == 0) ? GPIO_PIN_I : 32'h0, GPIO_IN);
         chk("alt1 in", (m == 1) ? GPIO_PIN_I : 32'h0, ALT1_IN);
         chk("alt2 in", (m == 2) ? GPIO_PIN_I : 32'h0, ALT2_IN);
         chk("sync in", (m == 1) ? GPIO_PIN_I[24] : 1'b1, SYNC_CLOCK_IN_N);
         chk("debug req", (m == 1) ? GPIO_PIN_I[31] : 1'b0, DEBUG_REQ);
      end
      @(negedge CLK);
      PORT_MODE_H = 32'h00050000;
      for (int k = 0; k < 2; k++) begin
         @(negedge CLK);
         SYNC_CLOCK_OUT_N = k[0];
         ALT1_DRV.o[25] = k[0];
         ALT1_DRV.oe_n[25] = 1'b0;
         #1;
         chk("sync out", {k[0], 1'b0}, {GPIO_PAD.o[25], GPIO_PAD.oe_n[25]});
      end
      $display("port modes done");
   endtask
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         conclude();
      end
   end
   initial begin
      CLK = 0; NRST = 0; ext_en = 1; dir_ext = 0; addr_ext = 0; MEM_ADDR = 24'h5AC33C; MEM_DIR = 0;
      PORT_MODE_L = 0; PORT_MODE_H = 0; SYNC_CLOCK_OUT_N = 1;
      // address pulls: 23,21,19..17 up; 22,20,16,15 down
      a_pull = 24'hAE0000; d_pull = 1'b1; g_pull = 32'hFFFFFFFF; h_pull = 13'h1FFF;
      l_pull = 16'hFFFF; far_en = 1'b1; g_ext = 32'h7E8118E7; h_ext = 13'h0A5A;
      l_ext = 16'hC3A5;
      GPIO_DRV = {32'h11112222, 32'hF0F00F0F}; ALT1_DRV = {32'hA5A55A5A, 32'h0000FFFF};
      ALT2_DRV = {32'h3C3CC3C3, 32'h00FFFF00}; ALT3_DRV = {32'h96966969, 32'hFF0000FF};
      HGPIO_O = 13'h1A5A; HGPIO_OE_N = 13'h0F0F; HBUS_HI_O = 13'h0B3C; HBUS_HI_OE_N = 13'h1234;
      HBUS_LO_O = 16'h1E2D; HBUS_LO_OE_N = 16'h00F0; DIAG_O = 16'h4B87; TRACE_O = 14'h2C71;
      t_straps(6'h00, 4'h9); t_hilo(6'h00);
      t_straps(6'h03, 4'h6); t_hilo(6'h03);
      t_straps(6'h2C, 4'hF); t_hilo(6'h2C);
      t_straps(6'h17, 4'h0); t_hilo(6'h17);
      t_modes();
      conclude();
   end
endmodule
